/* File: logic/ubg_consts.svh */
// Register offsets, field positions, reset values and timing counts of the rate generator block
`ifndef UBG_CONSTS_SVH
`define UBG_CONSTS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define UBG_ADR_BDH 8'h00
`define UBG_ADR_BDL 8'h04
`define UBG_ADR_CTRL1 8'h08
`define UBG_ADR_CTRL2 8'h0C
`define UBG_ADR_STATUS 8'h10
`define UBG_ADR_DATA 8'h14
`define UBG_ADR_MASK 8'h18
`define UBG_ADR_CTRL3 8'h1C
`define UBG_ADR_LINE 8'h20

// ----------------------------------------
// Reset values
// ----------------------------------------
`define UBG_BDL_RST 8'h04
`define UBG_REG_RST 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define UBG_BDH_BRK_IE 7
`define UBG_BDH_EDGE_IE 6
`define UBG_C1_NINE 4
`define UBG_C1_ADDR_WAKE 3
`define UBG_C1_IDLE_AFTER_STOP 2
`define UBG_C1_PAR_EN 1
`define UBG_C1_PAR_ODD 0
`define UBG_C2_DONE_IE 6
`define UBG_C2_FULL_IE 5
`define UBG_C2_IDLE_IE 4
`define UBG_C2_TX_EN 3
`define UBG_C2_RX_EN 2
`define UBG_C2_RX_SLEEP 1
`define UBG_C2_SEND_BRK 0
`define UBG_C3_TX_INV 4
`define UBG_C3_TX_BIT8 6
`define UBG_C3_RX_BIT8 7
`define UBG_ST_RX_FULL 0
`define UBG_ST_TX_DONE 1
`define UBG_ST_IDLE 2
`define UBG_ST_OVERRUN 3
`define UBG_ST_PAR_ERR 4
`define UBG_ST_FRAME_ERR 5
`define UBG_ST_RX_EDGE 6
`define UBG_ST_LINE_BRK 7

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define UBG_TICKS_PER_BIT 8'h10
`define UBG_TX_BRK_BITS 4'hD
`define UBG_RX_BRK_BITS 8'h0B
`define UBG_IDLE_BITS 8'h0A
`define UBG_RX_BRK_TICKS (8'(`UBG_RX_BRK_BITS * `UBG_TICKS_PER_BIT))

`endif

/* File: logic/ubg_pkg.sv */
// Types shared by the rate generator, transmitter and register block
package ubg_pkg;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } ubg_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } ubg_wb_rsp_t;

    typedef struct packed {
        logic nine_bit;
        logic par_en;
        logic par_odd;
        logic invert;
    } ubg_tx_cfg_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SHIFT = 2'b10
    } ubg_tx_st_t;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b001,
        RX_START = 3'b010,
        RX_DATA = 3'b100
    } ubg_rx_st_t;

    typedef struct packed {
        ubg_tx_st_t st;
        logic [12:0] frame;
        logic [3:0] left;
        logic [3:0] sub;
        logic txd;
        logic done;
    } ubg_tx_state_t;

    typedef struct packed {
        logic rx_meta;
        logic rx_sync;
        logic rx_prev;
        logic [7:0] bdh;
        logic [4:0] div_hi;
        logic [7:0] div_lo;
        logic [7:0] ctrl1;
        logic [7:0] ctrl2;
        logic [7:0] ctrl3;
        logic [7:0] mask;
        logic [7:0] status;
        logic armed;
        logic [8:0] rx_data;
        logic rx_full;
        ubg_rx_st_t rx_st;
        logic [3:0] rsub;
        logic [3:0] rbits;
        logic [9:0] rshift;
        logic [7:0] idle_cnt;
        logic idle_done;
        logic [7:0] low_cnt;
        logic brk_done;
        logic tx_pend;
        logic [8:0] tx_dat;
        logic tx_start;
        logic tx_brk;
        ubg_wb_rsp_t rsp;
        logic irq;
    } ubg_top_state_t;

endpackage

/* File: logic/ubg_baud_gen.sv */
// Modulo down-counter that emits the sixteen-per-bit oversampling tick
module ubg_baud_gen #(
    parameter int DIV_W = 13
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic run_i,
    input wire logic [DIV_W-1:0] div_i,
    // Tick
    output logic tick_o
);
    import ubg_pkg::*;

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic tick;
    } ubg_bg_state_t;

    ubg_bg_state_t s;
    ubg_bg_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (!run_i || div_i == '0) begin
            // Stopped generator holds no count so a restart ticks at once
            next_s.cnt = '0;
        end else if (s.cnt == '0) begin
            next_s.cnt = div_i - 1'b1;
            next_s.tick = 1'b1;
        end else begin
            next_s.cnt = s.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick_o = s.tick;
endmodule // ubg_baud_gen

/* File: logic/ubg_uart_tx.sv */
// Transmit shifter: start, data, optional parity, stop, or a long break
`include "ubg_consts.svh"
module ubg_uart_tx (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Rate and requests
    input wire logic tick_i,
    input wire logic start_i,
    input wire logic brk_i,
    input wire logic [8:0] data_i,
    input wire ubg_pkg::ubg_tx_cfg_t cfg_i,
    // Line and status
    output logic txd_o,
    output logic busy_o,
    output logic done_o
);
    import ubg_pkg::*;

    ubg_tx_state_t s;
    ubg_tx_state_t next_s;

    always_comb begin
        logic [8:0] pay;
        logic line;
        pay = data_i;
        line = 1'b1;
        next_s = s;
        next_s.done = 1'b0;
        if (cfg_i.par_en) begin
            if (cfg_i.nine_bit) begin
                pay[8] = ^data_i[7:0] ^ cfg_i.par_odd;
            end else begin
                pay[7] = ^data_i[6:0] ^ cfg_i.par_odd;
            end
        end
        unique case (s.st)
            TX_IDLE: begin
                next_s.sub = 4'h0;
                if (brk_i) begin
                    next_s.frame = 13'h0000;
                    next_s.left = `UBG_TX_BRK_BITS;
                    next_s.st = TX_SHIFT;
                end else if (start_i) begin
                    if (cfg_i.nine_bit) begin
                        next_s.frame = {3'h7, pay, 1'b0};
                        next_s.left = 4'hB;
                    end else begin
                        next_s.frame = {4'hF, pay[7:0], 1'b0};
                        next_s.left = 4'hA;
                    end
                    next_s.st = TX_SHIFT;
                end
            end
            TX_SHIFT: begin
                if (tick_i) begin
                    next_s.sub = s.sub + 4'h1;
                    if (s.sub == 4'hF) begin
                        next_s.frame = {1'b1, s.frame[12:1]};
                        next_s.left = s.left - 4'h1;
                        if (s.left == 4'h1) begin
                            next_s.st = TX_IDLE;
                            next_s.done = 1'b1;
                        end
                    end
                end
            end
        endcase
        if (next_s.st == TX_SHIFT) begin
            line = next_s.frame[0];
        end
        next_s.txd = line ^ cfg_i.invert;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '{st: TX_IDLE, txd: 1'b1, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign txd_o = s.txd;
    assign busy_o = (s.st == TX_SHIFT);
    assign done_o = s.done;
endmodule // ubg_uart_tx

/* File: logic/ubg_top.sv */
// Serial interface with its rate generator, registers on classic Wishbone
`include "ubg_consts.svh"
module ubg_top #(
    parameter int DIV_W = 13
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire ubg_pkg::ubg_wb_req_t wb_i,
    output ubg_pkg::ubg_wb_rsp_t wb_o,
    // Serial line
    input wire logic rxd_i,
    output logic txd_o,
    // Interrupt
    output logic irq_o
);
    import ubg_pkg::*;

    ubg_top_state_t s;
    ubg_top_state_t next_s;
    logic tick;
    logic tx_busy;
    logic tx_done;
    ubg_tx_cfg_t tx_cfg;

    // ----------------------------------------
    // Shared rate generator and transmitter
    // ----------------------------------------
    ubg_baud_gen #(
        .DIV_W(DIV_W)
    ) u_gen (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(s.armed),
        .div_i({s.div_hi, s.div_lo}),
        .tick_o(tick)
    );

    assign tx_cfg = '{
        nine_bit: s.ctrl1[`UBG_C1_NINE],
        par_en: s.ctrl1[`UBG_C1_PAR_EN],
        par_odd: s.ctrl1[`UBG_C1_PAR_ODD],
        invert: s.ctrl3[`UBG_C3_TX_INV]
    };

    ubg_uart_tx u_tx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .start_i(s.tx_start),
        .brk_i(s.tx_brk),
        .data_i(s.tx_dat),
        .cfg_i(tx_cfg),
        .txd_o(txd_o),
        .busy_o(tx_busy),
        .done_o(tx_done)
    );

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        logic req;
        logic wr;
        logic rd;
        logic re;
        logic te;
        logic nine;
        logic div_nz;
        logic accept;
        logic par_x;
        logic par_bad;
        logic [7:0] evt;
        logic [7:0] en;
        logic [7:0] src;
        logic [7:0] idle_lim;
        logic [9:0] sh;
        logic [8:0] rdat;
        logic [31:0] rval;
        // Ack follows the request by one cycle; effects land at the ack edge
        req = wb_i.cyc & wb_i.stb & ~s.rsp.ack;
        wr = s.rsp.ack & wb_i.cyc & wb_i.stb & wb_i.we;
        rd = s.rsp.ack & wb_i.cyc & wb_i.stb & ~wb_i.we;
        re = s.ctrl2[`UBG_C2_RX_EN];
        te = s.ctrl2[`UBG_C2_TX_EN];
        nine = s.ctrl1[`UBG_C1_NINE];
        div_nz = ({s.div_hi, s.div_lo} != 13'h0000);
        accept = 1'b0;
        evt = 8'h00;
        en = 8'h00;
        src = 8'h00;
        sh = {s.rx_sync, s.rshift[9:1]};
        rdat = 9'h000;
        rval = 32'h0000_0000;
        next_s = s;

        // Two-flop synchroniser; only the second stage feeds logic
        next_s.rx_meta = rxd_i;
        next_s.rx_sync = s.rx_meta;
        next_s.rx_prev = s.rx_sync;
        if (s.rx_prev && !s.rx_sync) begin
            evt[`UBG_ST_RX_EDGE] = 1'b1;
        end

        // Break: a low line held for the break length in ticks
        if (s.rx_sync) begin
            next_s.low_cnt = 8'h00;
            next_s.brk_done = 1'b0;
        end else if (tick && re && !s.brk_done) begin
            next_s.low_cnt = s.low_cnt + 8'h01;
            if (s.low_cnt == `UBG_RX_BRK_TICKS - 8'h01) begin
                next_s.brk_done = 1'b1;
                evt[`UBG_ST_LINE_BRK] = 1'b1;
            end
        end

        // Idle: one flag per stretch of high line, one character long
        if (nine) begin
            idle_lim = 8'((`UBG_IDLE_BITS + 8'h01) * `UBG_TICKS_PER_BIT);
        end else begin
            idle_lim = 8'(`UBG_IDLE_BITS * `UBG_TICKS_PER_BIT);
        end
        if (!s.rx_sync) begin
            next_s.idle_cnt = 8'h00;
            next_s.idle_done = 1'b0;
        end else if (tick && re && !s.idle_done) begin
            next_s.idle_cnt = s.idle_cnt + 8'h01;
            if (s.idle_cnt == idle_lim - 8'h01) begin
                next_s.idle_done = 1'b1;
                evt[`UBG_ST_IDLE] = 1'b1;
                if (!s.ctrl1[`UBG_C1_ADDR_WAKE]) begin
                    next_s.ctrl2[`UBG_C2_RX_SLEEP] = 1'b0;
                end
            end
        end

        // Receiver on the shared tick
        unique case (s.rx_st)
            RX_IDLE: begin
                next_s.rsub = 4'h0;
                if (tick && re && !s.rx_sync) begin
                    next_s.rx_st = RX_START;
                end
            end
            RX_START: begin
                if (tick) begin
                    next_s.rsub = s.rsub + 4'h1;
                    if (s.rsub == 4'h7) begin
                        // Mid start bit: a glitch falls back to idle
                        next_s.rsub = 4'h0;
                        next_s.rbits = 4'h0;
                        if (s.rx_sync) begin
                            next_s.rx_st = RX_IDLE;
                        end else begin
                            next_s.rx_st = RX_DATA;
                        end
                    end
                end
            end
            RX_DATA: begin
                if (tick) begin
                    next_s.rsub = s.rsub + 4'h1;
                    if (s.rsub == 4'hF) begin
                        next_s.rshift = sh;
                        next_s.rbits = s.rbits + 4'h1;
                        if (s.rbits == (nine ? 4'h9 : 4'h8)) begin
                            next_s.rx_st = RX_IDLE;
                            accept = 1'b1;
                        end
                    end
                end
            end
        endcase

        // Completed character: stop bit, parity, wakeup, buffer
        if (nine) begin
            rdat = sh[8:0];
            par_x = ^sh[8:0];
        end else begin
            rdat = {1'b0, sh[8:1]};
            par_x = ^sh[8:1];
        end
        par_bad = s.ctrl1[`UBG_C1_PAR_EN] & (par_x ^ s.ctrl1[`UBG_C1_PAR_ODD]);
        if (accept) begin
            if (!sh[9]) begin
                evt[`UBG_ST_FRAME_ERR] = 1'b1;
            end
            if (par_bad) begin
                evt[`UBG_ST_PAR_ERR] = 1'b1;
            end
            // Address-marked character wakes a sleeping receiver
            if (s.ctrl1[`UBG_C1_ADDR_WAKE] && (nine ? rdat[8] : rdat[7])) begin
                next_s.ctrl2[`UBG_C2_RX_SLEEP] = 1'b0;
            end
            if (!next_s.ctrl2[`UBG_C2_RX_SLEEP]) begin
                if (s.rx_full) begin
                    evt[`UBG_ST_OVERRUN] = 1'b1;
                end else begin
                    next_s.rx_full = 1'b1;
                    next_s.rx_data = rdat;
                    evt[`UBG_ST_RX_FULL] = 1'b1;
                end
            end
            if (s.ctrl1[`UBG_C1_IDLE_AFTER_STOP]) begin
                next_s.idle_cnt = 8'h00;
            end
        end

        // Frames start only on a running, nonzero divisor, else the line would stick low
        next_s.tx_start = 1'b0;
        next_s.tx_brk = 1'b0;
        if (te && s.armed && div_nz && !tx_busy && !s.tx_start && !s.tx_brk) begin
            if (s.ctrl2[`UBG_C2_SEND_BRK]) begin
                next_s.tx_brk = 1'b1;
            end else if (s.tx_pend) begin
                next_s.tx_start = 1'b1;
                next_s.tx_pend = 1'b0;
            end
        end
        if (tx_done) begin
            evt[`UBG_ST_TX_DONE] = 1'b1;
        end

        // Read data is taken at the request and held with ack
        next_s.rsp.ack = req;
        if (req) begin
            case (wb_i.adr)
                `UBG_ADR_BDH: begin
                    rval = {24'h0, s.bdh[7:6], 1'b0, s.bdh[4:0]};
                end
                `UBG_ADR_BDL: begin
                    rval = {24'h0, s.div_lo};
                end
                `UBG_ADR_CTRL1: begin
                    rval = {24'h0, s.ctrl1};
                end
                `UBG_ADR_CTRL2: begin
                    rval = {24'h0, s.ctrl2};
                end
                `UBG_ADR_CTRL3: begin
                    rval = {24'h0, s.rx_data[8], s.ctrl3[6:0]};
                end
                `UBG_ADR_STATUS: begin
                    rval = {24'h0, s.status};
                end
                `UBG_ADR_DATA: begin
                    rval = {24'h0, s.rx_data[7:0]};
                end
                `UBG_ADR_MASK: begin
                    rval = {24'h0, s.mask};
                end
                `UBG_ADR_LINE: begin
                    rval = {31'h0, s.rx_sync};
                end
                default: begin
                    rval = 32'h0000_0000;
                end
            endcase
            next_s.rsp.dat = rval;
        end

        // Register writes; software wins over hardware on control bits
        if (wr) begin
            case (wb_i.adr)
                `UBG_ADR_BDH: begin
                    // Upper bits stay buffered until the lower write
                    next_s.bdh = wb_i.dat[7:0];
                end
                `UBG_ADR_BDL: begin
                    next_s.div_lo = wb_i.dat[7:0];
                    next_s.div_hi = s.bdh[4:0];
                end
                `UBG_ADR_CTRL1: begin
                    next_s.ctrl1 = wb_i.dat[7:0];
                end
                `UBG_ADR_CTRL2: begin
                    next_s.ctrl2 = wb_i.dat[7:0];
                    if (wb_i.dat[`UBG_C2_TX_EN] || wb_i.dat[`UBG_C2_RX_EN]) begin
                        next_s.armed = 1'b1;
                    end
                end
                `UBG_ADR_CTRL3: begin
                    next_s.ctrl3 = wb_i.dat[7:0];
                end
                `UBG_ADR_DATA: begin
                    next_s.tx_pend = 1'b1;
                    next_s.tx_dat = {s.ctrl3[`UBG_C3_TX_BIT8], wb_i.dat[7:0]};
                end
                `UBG_ADR_MASK: begin
                    next_s.mask = wb_i.dat[7:0];
                end
                default: begin
                end
            endcase
        end
        if (rd && wb_i.adr == `UBG_ADR_DATA && !evt[`UBG_ST_RX_FULL]) begin
            next_s.rx_full = 1'b0;
        end

        // A flag raised in the cycle of its clearing read stays set
        if (rd && wb_i.adr == `UBG_ADR_STATUS) begin
            next_s.status = evt;
        end else begin
            next_s.status = s.status | evt;
        end
        en[`UBG_ST_LINE_BRK] = next_s.bdh[`UBG_BDH_BRK_IE];
        en[`UBG_ST_RX_EDGE] = next_s.bdh[`UBG_BDH_EDGE_IE];
        en[`UBG_ST_RX_FULL] = next_s.ctrl2[`UBG_C2_FULL_IE];
        en[`UBG_ST_TX_DONE] = next_s.ctrl2[`UBG_C2_DONE_IE];
        en[`UBG_ST_IDLE] = next_s.ctrl2[`UBG_C2_IDLE_IE];
        en[`UBG_ST_OVERRUN] = 1'b1;
        en[`UBG_ST_PAR_ERR] = 1'b1;
        en[`UBG_ST_FRAME_ERR] = 1'b1;
        src = next_s.status;
        // Receive-full asks while the buffer holds data, not only once
        src[`UBG_ST_RX_FULL] = next_s.rx_full;
        // A set mask bit holds its source back
        next_s.irq = |(src & en & ~next_s.mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Line samples reset to idle high, so no false edge follows reset
            s <= '{
                rx_meta: 1'b1,
                rx_sync: 1'b1,
                rx_prev: 1'b1,
                div_lo: `UBG_BDL_RST,
                rx_st: RX_IDLE,
                default: '0
            };
        end else begin
            s <= next_s;
        end
    end

    assign wb_o = s.rsp;
    assign irq_o = s.irq;
endmodule // ubg_top

/* File: sim/ubg_props.sv */
// Port checker of the rate generator block
`include "ubg_consts.svh"
module ubg_props #(
    parameter int DIV_W = 13
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Observed ports
    input wire ubg_pkg::ubg_wb_req_t wb_i,
    input wire ubg_pkg::ubg_wb_rsp_t wb_o,
    input wire logic txd_o,
    input wire logic irq_o
);
    import ubg_pkg::*;
    logic armed;
    logic inv;
    logic bdl_wr;
    logic [4:0] hi_buf;
    logic [DIV_W-1:0] div_work;
    wire logic wr = wb_o.ack && wb_i.we;
    // Shadow of the working divisor, as software set it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            armed <= 1'b0;
            inv <= 1'b0;
            bdl_wr <= 1'b0;
            hi_buf <= 5'h00;
            div_work <= DIV_W'(`UBG_BDL_RST);
        end else if (wr) begin
            if (wb_i.adr == `UBG_ADR_CTRL2 && wb_i.dat[3:2] != 2'b00) begin
                armed <= 1'b1;
            end
            if (wb_i.adr == `UBG_ADR_CTRL3) begin
                inv <= wb_i.dat[`UBG_C3_TX_INV];
            end
            if (wb_i.adr == `UBG_ADR_BDH) begin
                hi_buf <= wb_i.dat[4:0];
            end
            if (wb_i.adr == `UBG_ADR_BDL) begin
                bdl_wr <= 1'b1;
                div_work <= DIV_W'({hi_buf, wb_i.dat[7:0]});
            end
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_has_req_a: assert property (wb_o.ack |-> wb_i.cyc && wb_i.stb)
        else $error("ack without request");
    ack_pulse_a: assert property (wb_o.ack |=> !wb_o.ack)
        else $error("ack held two cycles");
    ack_bound_a: assert property (wb_i.cyc && wb_i.stb |-> ##[0:8] wb_o.ack)
        else $error("ack late");
    rd_upper_zero_a: assert property (wb_o.ack && !wb_i.we |-> wb_o.dat[31:8] == 24'h0)
        else $error("read data above byte");
    idle_mark_a: assert property (!armed && $stable(inv) |-> txd_o != inv)
        else $error("line active before enable");
    irq_after_rst_a: assert property ($past(rst_i) |-> !irq_o)
        else $error("irq right after reset");
    bdl_reset_a: assert property (wb_o.ack && !wb_i.we && wb_i.adr == `UBG_ADR_BDL && !bdl_wr
        |-> wb_o.dat[7:0] == `UBG_BDL_RST)
        else $error("low divisor reset value");
    zero_stop_a: assert property (div_work == '0 |=> $stable(txd_o))
        else $error("line moved at zero divisor");
    cover property (wr);
    cover property (wb_o.ack && !wb_i.we);
    cover property ($rose(irq_o));
endmodule // ubg_props

bind ubg_top ubg_props #(.DIV_W(DIV_W)) u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
    .wb_o(wb_o), .txd_o(txd_o), .irq_o(irq_o));

/* File: sim/ubg_line_model.sv */
// Far-end serial port driving the receive line
module ubg_line_model (
    // Clock
    input wire logic clk_i,
    // Line
    output logic rxd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rxd_o = 1'b1;
    // Hold the line low, a break when long enough
    task send_low(input int n);
        rxd_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        rxd_o <= 1'b1;
    endtask
endmodule // ubg_line_model

/* File: sim/uart_baud_rate_generator_tb.sv */
// Register-level testbench of the rate generator block
`include "ubg_consts.svh"
module uart_baud_rate_generator_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ubg_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    ubg_wb_req_t wb_i = '0;
    ubg_wb_rsp_t wb_o;
    logic rxd_i;
    logic txd_o;
    logic irq_o;
    logic [31:0] rd;
    int n_mismatch = 0;
    int total_checks = 0;
    int len;
    always #4 clk_i = ~clk_i;
    ubg_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o), .rxd_i(rxd_i),
        .txd_o(txd_o), .irq_o(irq_o));
    ubg_line_model line (.clk_i(clk_i), .rxd_o(rxd_i));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task results;
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Classic Wishbone single cycle
    // ----------------------------------------
    task bus(input logic we, input logic [7:0] adr, input logic [7:0] dat);
        int i;
        i = 0;
        wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h0, dat}};
        do begin
            @(posedge clk_i);
            i++;
        end while (wb_o.ack !== 1'b1 && i < 50);
        rd = wb_o.dat;
        wb_i <= '0;
        if (wb_o.ack !== 1'b1) begin
            n_mismatch++;
            results();
        end
        @(posedge clk_i);
    endtask
    // Second data bit of 0x55 in clocks; its edges sit on the tick grid
    task bit_len;
        int i;
        len = 0;
        for (i = 0; i < 2000 && txd_o !== 1'b0; i++) @(posedge clk_i);
        if (txd_o === 1'b0) begin
            for (i = 0; i < 9000 && txd_o !== 1'b1; i++) @(posedge clk_i);
            for (i = 0; i < 9000 && txd_o !== 1'b0; i++) @(posedge clk_i);
            while (txd_o === 1'b0 && len < 9000) begin
                @(posedge clk_i);
                len++;
            end
        end
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, `UBG_ADR_BDL, 8'h00);
        check(rd, 32'h04);
        bus(1'b0, `UBG_ADR_BDH, 8'h00);
        check(rd, 32'h00);
        bus(1'b0, 8'h3C, 8'h00);
        repeat (100) @(posedge clk_i);
        check(txd_o, 1'b1);
        bus(1'b1, `UBG_ADR_CTRL2, 8'h01 << `UBG_C2_TX_EN);
        bus(1'b1, `UBG_ADR_DATA, 8'h55);
        bit_len();
        check(len, 64);
        repeat (700) @(posedge clk_i);
        bus(1'b1, `UBG_ADR_BDH, 8'h01);
        bus(1'b1, `UBG_ADR_DATA, 8'h55);
        bit_len();
        check(len, 64);
        repeat (700) @(posedge clk_i);
        bus(1'b1, `UBG_ADR_BDL, 8'h02);
        bus(1'b0, `UBG_ADR_BDH, 8'h00);
        check(rd, 32'h01);
        bus(1'b0, `UBG_ADR_BDL, 8'h00);
        check(rd, 32'h02);
        bus(1'b1, `UBG_ADR_DATA, 8'h55);
        bit_len();
        check(len, 16 * 258);
        // Reset in mid-frame, then a zero divisor
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b1, `UBG_ADR_BDL, 8'h00);
        bus(1'b1, `UBG_ADR_CTRL2, 8'h0C);
        bus(1'b1, `UBG_ADR_DATA, 8'h55);
        bit_len();
        check(len, 0);
        bus(1'b1, `UBG_ADR_BDL, 8'h04);
        bus(1'b1, `UBG_ADR_BDH, 8'hC0);
        line.send_low(64 * 12);
        repeat (4) @(posedge clk_i);
        check(irq_o, 1'b1);
        bus(1'b0, `UBG_ADR_STATUS, 8'h00);
        check(rd[7:6], 2'b11);
        bus(1'b0, `UBG_ADR_STATUS, 8'h00);
        check(rd[7:6], 2'b00);
        check(irq_o, 1'b0);
        bus(1'b1, `UBG_ADR_MASK, 8'hFF);
        line.send_low(64);
        repeat (4) @(posedge clk_i);
        check(irq_o, 1'b0);
        results();
    end
endmodule // uart_baud_rate_generator_tb
